// File: hdl/rtfc_pkg.sv
// Constants for the RX/TX FIFO control block: offsets, field positions, states.
// Assumes a 32-bit Avalon-MM slave on the same clock as the FIFO logic.
// Contract
// - Writing one to receive discard resets RX data and status pointers, then clears.
// - Five-bit receive data offset shifts packet start by 0 to 31 bytes.
// - Upper three offset bits may change anytime; applied from next DWORD read.
// - End alignment: 00 four bytes, 01 sixteen, 10 thirty-two, 11 reserved.
// - Writing one to TX status discard zeroes TX status pointers, then clears.
// - Writing one to TX data discard zeroes TX data pointers, then clears.
// - Overrun allow clear: full TX status FIFO suspends sending; set: continue.
// - TX status full interrupt is raised regardless of the overrun allow bit.
// - While transmitter enable is one, transmitter is active and sends data.
// - Device clears transmitter enable once stop was requested and transmitter halted.
// - Stop request: finish current frame, stop, then clear the stop bit.
// - While stop request reads one, host writes to it are ignored.
// - Filler DWORDs are appended at buffer end to meet the end alignment.
package rtfc_pkg;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] RX_CONFIG_OFF = 8'h6c;
  localparam logic [7:0] TX_CONFIG_OFF = 8'h70;
  localparam logic [7:0] INT_STS_OFF = 8'h80;
  localparam logic [7:0] INT_MASK_OFF = 8'h84;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RX_ALIGN_LSB = 30;
  localparam int RX_DUMP_BIT = 15;
  localparam int RX_OFF_LSB = 8;
  localparam int RX_OFF_W = 5;
  localparam int RX_OFF_LOW_W = 2;
  localparam int TX_SDUMP_BIT = 15;
  localparam int TX_DDUMP_BIT = 14;
  localparam int TX_ALLOW_BIT = 2;
  localparam int TX_ON_BIT = 1;
  localparam int TX_STOP_BIT = 0;
  localparam logic [31:0] RX_CONFIG_RMASK = 32'hc000_9f00;
  localparam logic [31:0] TX_CONFIG_RMASK = 32'h0000_c007;
  // ****************************************************************
  // Interrupt status bits
  // ****************************************************************
  localparam int INT_W = 4;
  localparam int IRQ_TSFULL = 0;
  localparam int IRQ_TXHALT = 1;
  localparam int IRQ_RXDUMP = 2;
  localparam int IRQ_TXDUMP = 3;
  // ****************************************************************
  // Types and reset values
  // ****************************************************************
  typedef enum logic [1:0] {
    RTFC_AL4 = 2'h0, RTFC_AL16 = 2'h1, RTFC_AL32 = 2'h2, RTFC_ALRSV = 2'h3
  } rtfc_align_t;
  typedef enum logic [2:0] {
    RTFC_TX_OFF = 3'h1, RTFC_TX_RUN = 3'h2, RTFC_TX_DRAIN = 3'h4
  } rtfc_tx_t;
  localparam int PAD_W = 3;
  localparam logic [PAD_W-1:0] PAD_MASK4 = 3'h0;
  localparam logic [PAD_W-1:0] PAD_MASK16 = 3'h3;
  localparam logic [PAD_W-1:0] PAD_MASK32 = 3'h7;
endpackage

// File: hdl/rtfc_pad.sv
// End-of-buffer filler counter for the RX data path.
// Assumes pulses from same-clock read logic; align stays put within a packet.
`timescale 1ns/1ps
module rtfc_pad import rtfc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Read events
  input wire logic buf_start,
  input wire logic dword_rd,
  input wire logic last_data,
  input wire rtfc_align_t align,
  input wire logic flush,
  // Filler state
  output logic pad_active_q,
  output logic [PAD_W-1:0] pad_left_q
);
  logic [PAD_W-1:0] cnt_q;
  logic [PAD_W-1:0] mask;
  logic [PAD_W-1:0] pad_d;

  always_comb begin
    case (align)
      RTFC_AL16: mask = PAD_MASK16;
      RTFC_AL32: mask = PAD_MASK32;
      default: mask = PAD_MASK4;   // Reserved code behaves as 4-byte, no filler
    endcase
    pad_d = (cnt_q + 3'h1) ^ mask;
    pad_d = (pad_d + 3'h1) & mask;  // Words missing to next boundary
  end

  // Data words counted modulo the largest alignment
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (buf_start || flush) begin
        cnt_q <= '0;
      end else if (dword_rd && !pad_active_q) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pad_left_q <= '0;
      pad_active_q <= 1'b0;
    end else if (ce) begin
      if (flush || buf_start) begin
        pad_left_q <= '0;
        pad_active_q <= 1'b0;
      end else if (dword_rd && last_data && !pad_active_q) begin
        pad_left_q <= pad_d;
        pad_active_q <= (pad_d != '0);
      end else if (dword_rd && pad_active_q) begin
        pad_left_q <= pad_left_q - 3'h1;
        pad_active_q <= (pad_left_q != 3'h1);
      end
    end
  end
endmodule // rtfc_pad

// File: hdl/rtfc_ctrl.sv
// Top of the RX/TX FIFO control block: register slave, TX enable and stop
// sequencing, discards, RX offset and filler, interrupt.
// Assumes FIFO and MAC logic on sys_clk drive the status inputs.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module rtfc_ctrl import rtfc_pkg::*; (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Transmit side
  input wire logic tx_status_full,
  input wire logic tx_frame_busy,
  output logic tx_go,
  output logic tx_status_discard,
  output logic tx_data_fifo_clr,
  // Receive side
  input wire logic rx_buf_start,
  input wire logic rx_dword_rd,
  input wire logic rx_last_data,
  output logic rx_fifo_clr,
  output logic [RX_OFF_W-1:0] rx_data_offset,
  output logic rx_pad_active,
  // Interrupt
  output logic irq
);
  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic wait_q;
  logic take;
  logic wr_rx;
  logic wr_tx;
  logic wr_sts;
  logic wr_mask;
  logic [31:0] rd_d;
  logic [31:0] rx_config_rd;
  logic [31:0] tx_config_rd;

  rtfc_align_t align_q;
  logic [RX_OFF_W-1:0] off_q;
  logic rx_dump_q;
  logic tx_sdump_q;
  logic tx_ddump_q;
  logic allow_q;
  rtfc_tx_t tx_q;
  logic [INT_W-1:0] sts_q;
  logic [INT_W-1:0] mask_q;
  logic [INT_W-1:0] ev;
  logic full_seen_q;
  logic [PAD_W-1:0] pad_left;

  assign take = (avs_read || avs_write) && !wait_q;
  assign wr_rx = take && avs_write && (avs_address == RX_CONFIG_OFF);
  assign wr_tx = take && avs_write && (avs_address == TX_CONFIG_OFF);
  assign wr_sts = take && avs_write && (avs_address == INT_STS_OFF);
  assign wr_mask = take && avs_write && (avs_address == INT_MASK_OFF);
  // Straight from its flop, so the stall line never glitches on address decode
  assign avs_waitrequest = wait_q;

  always_comb begin
    rx_config_rd = '0;
    rx_config_rd[RX_ALIGN_LSB +: 2] = align_q;
    rx_config_rd[RX_DUMP_BIT] = rx_dump_q;
    rx_config_rd[RX_OFF_LSB +: RX_OFF_W] = off_q;
    rx_config_rd = rx_config_rd & RX_CONFIG_RMASK;
    tx_config_rd = '0;
    tx_config_rd[TX_SDUMP_BIT] = tx_sdump_q;
    tx_config_rd[TX_DDUMP_BIT] = tx_ddump_q;
    tx_config_rd[TX_ALLOW_BIT] = allow_q;
    tx_config_rd[TX_ON_BIT] = (tx_q != RTFC_TX_OFF);
    tx_config_rd[TX_STOP_BIT] = (tx_q == RTFC_TX_DRAIN);
    tx_config_rd = tx_config_rd & TX_CONFIG_RMASK;
    case (avs_address)
      RX_CONFIG_OFF: rd_d = rx_config_rd;
      TX_CONFIG_OFF: rd_d = tx_config_rd;
      INT_STS_OFF: rd_d = {{(32-INT_W){1'b0}}, sts_q};
      INT_MASK_OFF: rd_d = {{(32-INT_W){1'b0}}, mask_q};
      default: rd_d = '0;  // Unmapped reads return zero
    endcase
  end

  // One wait state: data captured on the first cycle, taken on the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      avs_readdata <= '0;
    end else if (ce) begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q) begin
        avs_readdata <= rd_d;
      end
    end
  end

  // ****************************************************************
  // Receive configuration
  // ****************************************************************
  // alignment field plain storage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      align_q <= RTFC_AL4;
      off_q <= '0;
    end else if (ce && wr_rx) begin
      align_q <= rtfc_align_t'(avs_writedata[RX_ALIGN_LSB +: 2]);
      off_q <= avs_writedata[RX_OFF_LSB +: RX_OFF_W];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_dump_q <= 1'b0;
      rx_fifo_clr <= 1'b0;
    end else if (ce) begin
      rx_fifo_clr <= rx_dump_q;
      // bit reads zero once pulse issued
      // New write wins over the self-clear
      rx_dump_q <= wr_rx && avs_writedata[RX_DUMP_BIT];
    end
  end

  // upper offset bits follow on the next DWORD read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_data_offset <= '0;
    end else if (ce) begin
      // low bits steady since the host only moves them when halted
      rx_data_offset[RX_OFF_LOW_W-1:0] <= off_q[RX_OFF_LOW_W-1:0];
      if (rx_dword_rd || rx_fifo_clr) begin
        rx_data_offset[RX_OFF_W-1:RX_OFF_LOW_W] <= off_q[RX_OFF_W-1:RX_OFF_LOW_W];
      end
    end
  end

  rtfc_pad u_pad (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .buf_start(rx_buf_start),
    .dword_rd(rx_dword_rd),
    .last_data(rx_last_data),
    .align(align_q),
    .flush(rx_fifo_clr),
    .pad_active_q(rx_pad_active),
    .pad_left_q(pad_left)
  );

  // ****************************************************************
  // Transmit configuration
  // ****************************************************************
  // status discard, also data discard
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_sdump_q <= 1'b0;
      tx_ddump_q <= 1'b0;
      tx_status_discard <= 1'b0;
      tx_data_fifo_clr <= 1'b0;
      allow_q <= 1'b0;
    end else if (ce) begin
      tx_status_discard <= tx_sdump_q;
      tx_data_fifo_clr <= tx_ddump_q;
      tx_sdump_q <= wr_tx && avs_writedata[TX_SDUMP_BIT];
      tx_ddump_q <= wr_tx && avs_writedata[TX_DDUMP_BIT];
      if (wr_tx) begin
        allow_q <= avs_writedata[TX_ALLOW_BIT];
      end
    end
  end

  // Enable and stop sequencing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_q <= RTFC_TX_OFF;
    end else if (ce) begin
      case (tx_q)
        RTFC_TX_OFF: begin
          if (wr_tx && avs_writedata[TX_ON_BIT] && !avs_writedata[TX_STOP_BIT]) begin
            tx_q <= RTFC_TX_RUN;
          end
        end
        RTFC_TX_RUN: begin
          if (wr_tx && avs_writedata[TX_STOP_BIT]) begin
            tx_q <= RTFC_TX_DRAIN;
          end else if (wr_tx && !avs_writedata[TX_ON_BIT]) begin
            tx_q <= RTFC_TX_OFF;
          end
        end
        RTFC_TX_DRAIN: begin
          // enable drops with the halt, also
          if (!tx_frame_busy) begin
            tx_q <= RTFC_TX_OFF;
          end
        end
        default: tx_q <= RTFC_TX_OFF;
      endcase
    end
  end

  // send while enabled, suspend on full unless allowed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_go <= 1'b0;
    end else if (ce) begin
      // Registered: the MAC sees the suspend one cycle late, never a glitch
      tx_go <= (tx_q == RTFC_TX_RUN) && !(tx_status_full && !allow_q);
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // full event independent of allow bit
  always_comb begin
    ev = '0;
    ev[IRQ_TSFULL] = tx_status_full && !full_seen_q;
    ev[IRQ_TXHALT] = (tx_q == RTFC_TX_DRAIN) && !tx_frame_busy;
    ev[IRQ_RXDUMP] = rx_fifo_clr;
    ev[IRQ_TXDUMP] = tx_status_discard || tx_data_fifo_clr;
  end

  // Sticky bits, write one to clear; a same-cycle event wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sts_q <= '0;
      mask_q <= '0;
      full_seen_q <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      full_seen_q <= tx_status_full;
      sts_q <= (sts_q & ~(wr_sts ? avs_writedata[INT_W-1:0] : {INT_W{1'b0}})) | ev;
      if (wr_mask) begin
        mask_q <= avs_writedata[INT_W-1:0];
      end
      irq <= |(sts_q & mask_q);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  rx_discard_a: assert property (wr_rx && avs_writedata[RX_DUMP_BIT] && ce ##1 ce
    |=> rx_fifo_clr)
    else $error("rx discard pulse missing");
  rx_sc_a: assert property (rx_fifo_clr && ce && !wr_rx |-> !rx_dump_q)
    else $error("rx discard bit did not clear");
  tx_sdump_a: assert property (wr_tx && avs_writedata[TX_SDUMP_BIT] && ce ##1 ce
    |=> tx_status_discard)
    else $error("tx status discard missing");
  tx_ddump_a: assert property (wr_tx && avs_writedata[TX_DDUMP_BIT] && ce ##1 ce
    |=> tx_data_fifo_clr)
    else $error("tx data discard missing");
  tx_suspend_a: assert property (ce && tx_status_full && !allow_q |=> !tx_go)
    else $error("sending while status FIFO full");
  tx_run_a: assert property (ce && tx_q == RTFC_TX_RUN && !tx_status_full |=> tx_go)
    else $error("enabled transmitter not sending");
  tx_halt_a: assert property (ce && tx_q == RTFC_TX_DRAIN && !tx_frame_busy
    |=> tx_q == RTFC_TX_OFF && !tx_go)
    else $error("stop did not halt transmitter");
  tx_finish_a: assert property (ce && tx_q == RTFC_TX_DRAIN && tx_frame_busy
    |=> tx_q == RTFC_TX_DRAIN)
    else $error("stop cut the current frame");
  stop_lock_a: assert property (tx_q == RTFC_TX_DRAIN && tx_frame_busy && wr_tx
    |=> tx_q == RTFC_TX_DRAIN)
    else $error("write changed pending stop");
  full_irq_a: assert property (ce && tx_status_full && !full_seen_q
    |=> sts_q[IRQ_TSFULL])
    else $error("status full event lost");
  offset_hold_a: assert property (ce && !rx_dword_rd && !rx_fifo_clr
    |=> $stable(rx_data_offset[RX_OFF_W-1:RX_OFF_LOW_W]))
    else $error("upper offset changed without a read");
  pad_bound_a: assert property (rx_pad_active |-> pad_left != '0 &&
    (align_q == RTFC_AL32 || pad_left <= PAD_MASK16))
    else $error("filler count out of range");
  // Bus answer, pulse width and interrupt level
  wait_one_a: assert property (ce && (avs_read || avs_write) && wait_q |=> !avs_waitrequest)
    else $error("bus answer not after one wait state");
  rx_pulse_a: assert property (ce && rx_fifo_clr |=> !rx_fifo_clr)
    else $error("rx pointer clear longer than one cycle");
  irq_set_a: assert property (ce && (sts_q & mask_q) != '0 |=> irq)
    else $error("unmasked status without interrupt");
  irq_clr_a: assert property (ce && (sts_q & mask_q) == '0 |=> !irq)
    else $error("interrupt without unmasked status");

  // Main scenarios
  stop_cov_c: cover property (tx_q == RTFC_TX_DRAIN ##[1:20] tx_q == RTFC_TX_OFF);
  pad_cov_c: cover property (rx_pad_active && align_q == RTFC_AL32);
  irq_cov_c: cover property (irq && sts_q[IRQ_TSFULL]);
  dump_cov_c: cover property (tx_status_discard && tx_data_fifo_clr);
  allow_cov_c: cover property (tx_go && tx_status_full);
endmodule // rtfc_ctrl

// File: verif/rtfc_host_model.sv
// Host processor model: an Avalon-MM master for the FIFO control registers.
// Assumes a slave on sys_clk that holds waitrequest high until it answers.
`timescale 1ns/1ps
module rtfc_host_model import rtfc_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Avalon-MM master side
  output logic [ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Idle bus from time zero
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
  end

  // One transfer, entered just after a rising edge; held until waitrequest low.
  // Released lines carry inverted values so a stale address never passes.
  task automatic xfer(input logic wr_en, input logic [ADDR_W-1:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~wd;
    // One idle edge so the next request never lands in the same time step
    @(posedge sys_clk);
  endtask

  // Register write
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    logic [31:0] unused;
    xfer(1'b1, a, wd, unused);
  endtask

  // Register read
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask
endmodule // rtfc_host_model

// File: verif/tb_top.sv
// Self-checking bench for the RX/TX FIFO control block.
// Assumes the host model drives the register bus; MAC and FIFO lines come from here.
`timescale 1ns/1ps
module tb_top import rtfc_pkg::*; ;
  logic sys_clk, rst, ce_en, irq, tx_go, ts_clr, td_clr, rx_clr, rx_pad_active;
  logic tx_status_full, tx_frame_busy, rx_buf_start, rx_dword_rd, rx_last_data;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [RX_OFF_W-1:0] rx_data_offset;
  int n_mismatch = 0, cmp_count = 0, n_rxclr = 0, n_tsclr = 0, n_tdclr = 0;

  rtfc_ctrl uut (.sys_clk(sys_clk), .rst(rst), .ce(ce_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_status_full(tx_status_full), .tx_frame_busy(tx_frame_busy), .tx_go(tx_go),
    .tx_status_discard(ts_clr), .tx_data_fifo_clr(td_clr), .rx_buf_start(rx_buf_start),
    .rx_dword_rd(rx_dword_rd), .rx_last_data(rx_last_data), .rx_fifo_clr(rx_clr),
    .rx_data_offset(rx_data_offset), .rx_pad_active(rx_pad_active), .irq(irq));
  rtfc_host_model host (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  // Count discard pulses seen at the pointer-clear outputs
  always @(posedge sys_clk) begin
    if (rx_clr === 1'b1) n_rxclr++;
    if (ts_clr === 1'b1) n_tsclr++;
    if (td_clr === 1'b1) n_tdclr++;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    host.rd(a, d);
    chk(d, exp, what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One RX data DWORD read, then an idle cycle
  task automatic rd_word(input logic last);
    rx_last_data <= last;
    rx_dword_rd <= 1'b1;
    @(posedge sys_clk);
    rx_dword_rd <= 1'b0;
    rx_last_data <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_regs;
    rdchk(RX_CONFIG_OFF, 32'h0000_0000, "rx cfg reset");
    rdchk(TX_CONFIG_OFF, 32'h0000_0000, "tx cfg reset");
    // Purge with the old offset before its low bits move (host duty)
    host.wr(RX_CONFIG_OFF, 32'h0000_8000);
    host.wr(RX_CONFIG_OFF, 32'hffff_7fff);
    rdchk(RX_CONFIG_OFF, 32'hc000_1f00, "rx reserved bits");
    host.wr(TX_CONFIG_OFF, 32'hffff_3ffc);
    rdchk(TX_CONFIG_OFF, 32'h0000_0004, "tx reserved bits");
    host.wr(8'h40, 32'hffff_ffff);
    rdchk(8'h40, 32'h0000_0000, "unmapped read");
    host.wr(RX_CONFIG_OFF, 32'h0000_9f00);
    host.wr(RX_CONFIG_OFF, 32'h0000_0000);
    host.wr(TX_CONFIG_OFF, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic test_discard;
    int r0, t0, d0;
    r0 = n_rxclr;
    t0 = n_tsclr;
    d0 = n_tdclr;
    host.wr(INT_MASK_OFF, 32'h0000_0000);
    host.wr(INT_STS_OFF, 32'h0000_000f);
    host.wr(RX_CONFIG_OFF, 32'h0000_8000);
    rdchk(RX_CONFIG_OFF, 32'h0000_0000, "rx discard self clears");
    host.wr(TX_CONFIG_OFF, 32'h0000_c000);
    rdchk(TX_CONFIG_OFF, 32'h0000_0000, "tx discards self clear");
    chk(32'(n_rxclr - r0), 32'h1, "rx pointer clear");
    chk(32'(n_tsclr - t0), 32'h1, "tx status clear");
    chk(32'(n_tdclr - d0), 32'h1, "tx data clear");
    rdchk(INT_STS_OFF, 32'h0000_000c, "discard events");
    chk({31'h0, irq}, 32'h0, "irq masked");
    host.wr(INT_MASK_OFF, 32'h0000_0004);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    host.wr(INT_STS_OFF, 32'h0000_0004);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    rdchk(INT_STS_OFF, 32'h0000_0008, "one bit cleared");
    host.wr(INT_STS_OFF, 32'h0000_000f);
    host.wr(INT_MASK_OFF, 32'h0000_0000);
    $display("test discard done");
  endtask

  task automatic test_tx;
    host.wr(TX_CONFIG_OFF, 32'h0000_0002);
    cyc(2);
    chk({31'h0, tx_go}, 32'h1, "enabled sends");
    // Full arrives while the clock enable is low: nothing may move until it returns
    ce_en <= 1'b0;
    tx_status_full <= 1'b1;
    cyc(3);
    chk({31'h0, tx_go}, 32'h1, "clock enable freezes");
    ce_en <= 1'b1;
    cyc(3);
    chk({31'h0, tx_go}, 32'h0, "full suspends");
    rdchk(INT_STS_OFF, 32'h0000_0001, "full event");
    host.wr(INT_STS_OFF, 32'h0000_0001);
    host.wr(TX_CONFIG_OFF, 32'h0000_0006);
    cyc(2);
    chk({31'h0, tx_go}, 32'h1, "overrun allowed");
    tx_status_full <= 1'b0;
    cyc(2);
    tx_status_full <= 1'b1;
    cyc(2);
    rdchk(INT_STS_OFF, 32'h0000_0001, "full event with allow");
    host.wr(INT_STS_OFF, 32'h0000_0001);
    tx_frame_busy <= 1'b1;
    host.wr(TX_CONFIG_OFF, 32'h0000_0007);
    cyc(2);
    chk({31'h0, tx_go}, 32'h0, "stop blocks sending");
    host.wr(TX_CONFIG_OFF, 32'h0000_0004);
    rdchk(TX_CONFIG_OFF, 32'h0000_0007, "stop write ignored");
    rdchk(INT_STS_OFF, 32'h0000_0000, "no halt mid frame");
    tx_frame_busy <= 1'b0;
    cyc(3);
    rdchk(TX_CONFIG_OFF, 32'h0000_0004, "enable and stop clear");
    rdchk(INT_STS_OFF, 32'h0000_0002, "halt event");
    tx_status_full <= 1'b0;
    host.wr(INT_STS_OFF, 32'h0000_000f);
    $display("test tx done");
  endtask

  task automatic test_rx;
    logic [2:0] exp_fill[4] = '{3'h0, 3'h1, 3'h5, 3'h0};
    int n;
    // Purge first so the offset low bits may legally change (host duty)
    host.wr(RX_CONFIG_OFF, 32'h0000_8000);
    for (int al = 0; al < 4; al++) begin
      host.wr(RX_CONFIG_OFF, {al[1:0], 30'h0});
      rx_buf_start <= 1'b1;
      @(posedge sys_clk);
      rx_buf_start <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 3; i++) rd_word(i == 2);
      n = 0;
      while (rx_pad_active === 1'b1 && n < 10) begin
        rd_word(1'b0);
        n++;
      end
      chk(32'(n), 32'(exp_fill[al]), "filler count");
    end
    host.wr(RX_CONFIG_OFF, 32'h0000_8000);
    host.wr(RX_CONFIG_OFF, 32'h0000_1600);
    cyc(2);
    chk(32'(rx_data_offset), 32'h02, "low offset bits");
    rd_word(1'b0);
    chk(32'(rx_data_offset), 32'h16, "offset applied");
    host.wr(RX_CONFIG_OFF, 32'h0000_1e00);
    cyc(2);
    chk(32'(rx_data_offset), 32'h16, "upper waits for read");
    rd_word(1'b0);
    chk(32'(rx_data_offset), 32'h1e, "upper on next read");
    $display("test rx done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ce_en = 1'b1;
    tx_status_full = 1'b0;
    tx_frame_busy = 1'b0;
    rx_buf_start = 1'b0;
    rx_dword_rd = 1'b0;
    rx_last_data = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    test_regs();
    test_discard();
    test_tx();
    test_rx();
    end_sim();
  end
  // The tests need well under 2000 cycles; a hang is cut at 20000
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // tb_top
